// *** src/sst_pkg.sv ***
package sst_pkg;

  // ==========================================================================
  // Timing of the countdown chain
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned TAP1_PERIOD_NS = 200;
  // The first tap toggles every half period; 5 cycles at 50 MHz.
  localparam int unsigned TAP1_HALF_CYC  = TAP1_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned CHAIN_TAPS     = 20;
  localparam int unsigned TAP_NINE       = 9;
  localparam logic [2:0]  PRE_CNT_RST    = 3'h0;
  localparam logic [19:0] CHAIN_RST      = 20'h00000;

  // ==========================================================================
  // Delay counter and decode masks, counted in last-tap periods
  // ==========================================================================
  localparam logic [7:0] DLY_RST      = 8'h00;
  localparam logic [7:0] DLY_MAX      = 8'hFF;
  localparam logic [7:0] DLY_SPINUP   = 8'h04;
  localparam logic [7:0] DLY_PURGE    = 8'h10;
  localparam logic [7:0] DLY_LOAD     = 8'h02;
  localparam logic [7:0] DLY_STOP     = 8'h01;
  localparam logic [7:0] DLY_NONE     = 8'h00;

  // ==========================================================================
  // Disk rotation detector
  // ==========================================================================
  localparam logic [7:0] ROT_RST      = 8'h00;
  localparam logic [7:0] ROT_LIMIT    = 8'h08;

  // ==========================================================================
  // Edge detector
  // ==========================================================================
  localparam logic [2:0] EDGE_SHIFT_RST = 3'h0;

  // Start phase decoded from {load heads, purge cycle}; Gray order.
  typedef enum logic [1:0] {
    PH_IDLE   = 2'h0,
    PH_PURGE  = 2'h1,
    PH_LOAD   = 2'h3,
    PH_LOADED = 2'h2
  } sst_phase_e;

  // Pins that arrive from outside the clock domain.
  typedef struct packed {
    logic power_clear;
    logic run_contact;
    logic stop_contact;
    logic host_line;
    logic cart_ok;
    logic heads_ret;
    logic disk_index;
    logic ext_emerg;
    logic speed_ok;
    logic pos_ok;
  } sst_pins_s;

  // Major sequencer flip-flops.
  typedef struct packed {
    logic run;
    logic end_of_run;
    logic purge;
    logic load;
    logic seq_ctl;
    logic brake;
    logic emerg_unload;
    logic timing_pulse;
  } sst_seq_s;

  // The host line idles high; resetting its synchroniser to that level keeps
  // the edge detector from seeing a false level change after reset.
  localparam sst_pins_s PINS_RST = '{host_line: 1'b1, default: 1'b0};
  localparam sst_seq_s  SEQ_RST  = '{emerg_unload: 1'b1, default: 1'b0};

endpackage

// *** src/sst_edge_det.sv ***
`timescale 1ns/1ps

// Shift-register edge detector: one clean pulse per settled level change.
module sst_edge_det
  import sst_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic level,
  output logic      pulse
);

  typedef struct packed {
    logic [2:0] shift;
    logic       pulse;
  } sst_edge_s;

  sst_edge_s st_q;
  sst_edge_s st_d;

  // ==========================================================================
  // Shift and compare
  // ==========================================================================
  // The pulse needs the new level in two stages, but a level that flickers for
  // a single cycle still pulses once as it leaves; the far end holds each level longer.
  always_comb begin
    st_d       = st_q;
    st_d.shift = {st_q.shift[1:0], level};
    st_d.pulse = (st_q.shift[0] == st_q.shift[1]) && (st_q.shift[1] != st_q.shift[2]);
  end

  // Registered state.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '{shift: EDGE_SHIFT_RST, pulse: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign pulse = st_q.pulse;

endmodule // sst_edge_det

// *** src/sst_sequencer.sv ***
`timescale 1ns/1ps

module sst_sequencer
  import sst_pkg::*;
#(
  parameter int unsigned LAST_TAP = CHAIN_TAPS
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       power_clear_in,
  input  wire logic [1:0] panel_run_stop_switch,
  input  wire logic       host_start_stop_line,
  input  wire logic       cartridge_seated_ok,
  input  wire logic       heads_retracted,
  input  wire logic       disk_index_pulse,
  input  wire logic       external_emergency,
  input  wire logic       spindle_speed_ok,
  input  wire logic       position_ok,
  output logic            countdown_tap_nine,
  output logic            countdown_last_tap,
  output logic            run_switch_pulse,
  output logic            start_drive_motor_pulse,
  output logic            clear_or_unload_n,
  output logic            disk_not_rotating_n,
  output logic            no_brake_cycle_n,
  output logic            any_emergency,
  output logic            position_monitor_init,
  output logic            heads_load_cmd,
  output sst_seq_s        seq_state
);

  typedef struct packed {
    sst_pins_s   sync1;
    sst_pins_s   sync2;
    logic        index_prev;
    logic [2:0]  pre_cnt;
    logic [19:0] chain;
    logic        tap9_prev;
    logic        last_prev;
    logic        gated_prev;
    logic [7:0]  dly_cnt;
    logic [7:0]  rot_cnt;
    logic        sw_latch;
    logic        fault_start;
    logic        fault_load;
    sst_seq_s    seq;
    logic        o_tap9;
    logic        o_last;
    logic        o_rsp;
    logic        o_sdm;
    logic        o_cou_n;
    logic        o_dnr_n;
    logic        o_nbc_n;
    logic        o_anyem;
    logic        o_pm_init;
    logic        o_hload;
  } sst_state_s;

  sst_state_s st_q;
  sst_state_s st_d;
  sst_pins_s  pins;
  logic       combined_level;
  logic       rsp;

  // ==========================================================================
  // Pin capture
  // ==========================================================================
  // Every pin is asynchronous to clk, so all of them pass two flops.
  always_comb begin
    pins.power_clear  = power_clear_in;
    pins.run_contact  = panel_run_stop_switch[0];
    pins.stop_contact = panel_run_stop_switch[1];
    pins.host_line    = host_start_stop_line;
    pins.cart_ok      = cartridge_seated_ok;
    pins.heads_ret    = heads_retracted;
    pins.disk_index   = disk_index_pulse;
    pins.ext_emerg    = external_emergency;
    pins.speed_ok     = spindle_speed_ok;
    pins.pos_ok       = position_ok;
  end

  // Latched switch merged with the inverted host line; either one toggles it.
  assign combined_level = st_q.sw_latch ^ ~st_q.sync2.host_line;

  sst_edge_det u_edge (
    .clk     (clk),
    .sys_rst (sys_rst),
    .level   (combined_level),
    .pulse   (rsp)
  );

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  // One clock domain replaces the ripple chain; each tap is still a counter
  // bit, so every tap is a square wave of twice the previous period.
  always_comb begin
    sst_pins_s  p;
    sst_seq_s   s;
    sst_seq_s   n;
    sst_phase_e phase;
    logic       pclr;
    logic       tap9;
    logic       last_tap;
    logic       last_tick;
    logic       gated;
    logic       gev;
    logic       decode;
    logic [7:0] mask;
    logic       not_rot;
    logic       anyem;
    logic       cou_n;
    logic       interlock;
    logic       run_set;

    st_d       = st_q;
    st_d.sync1 = pins;
    st_d.sync2 = st_q.sync1;
    p          = st_q.sync2;
    s          = st_q.seq;
    n          = st_q.seq;
    pclr       = p.power_clear;

    // Countdown chain: a synchronous prescaler then a binary chain.
    if (st_q.pre_cnt == 3'(TAP1_HALF_CYC - 1)) begin
      st_d.pre_cnt = PRE_CNT_RST;
      st_d.chain   = st_q.chain + 20'h00001;
    end else begin
      st_d.pre_cnt = st_q.pre_cnt + 3'h1;
    end
    tap9      = st_q.chain[TAP_NINE - 1];
    last_tap  = st_q.chain[LAST_TAP - 1];
    last_tick = last_tap & ~st_q.last_prev;
    st_d.tap9_prev = tap9;
    st_d.last_prev = last_tap;

    // Gated clock: tap nine while the timing pulse stands; its rising edge
    // is the only moment purge and load may move.
    gated           = tap9 & s.timing_pulse;
    gev             = gated & ~st_q.gated_prev;
    st_d.gated_prev = gated;

    // Phase decode of purge and load steers the delay decode, fault tests and start sequence below.
    phase = sst_phase_e'({s.load, s.purge});

    // Delay decode picks the bits that end the current state's wait.
    mask = DLY_NONE;
    if (s.seq_ctl && !s.run) begin
      mask = DLY_STOP;
    end else if (!s.seq_ctl && s.run) begin
      unique case (phase)
        PH_IDLE:   mask = DLY_SPINUP;
        PH_PURGE:  mask = DLY_PURGE;
        PH_LOAD:   mask = DLY_LOAD;
        PH_LOADED: mask = DLY_NONE;
      endcase
    end
    decode = (mask != DLY_NONE) && ((st_q.dly_cnt & mask) == mask);

    // Timing pulse moves on the falling edge of tap nine, so it is high for
    // one whole tap period and the gated clock rises in its middle.
    if (tap9 == 1'b0 && st_q.tap9_prev == 1'b1) begin
      n.timing_pulse = s.timing_pulse ? 1'b0 : decode;
    end

    // Rotation detector: an index pulse restarts it; reaching the limit
    // means the disk stands. After power clear it restarts from zero, which
    // gives the settling delay.
    st_d.index_prev = p.disk_index;
    if (p.disk_index && !st_q.index_prev) begin
      st_d.rot_cnt = ROT_RST;
    end else if (last_tick && st_q.rot_cnt != ROT_LIMIT) begin
      st_d.rot_cnt = st_q.rot_cnt + 8'h01;
    end
    not_rot = (st_q.rot_cnt == ROT_LIMIT);

    // Switch debounce latch: holds its level while both contacts are open
    // or bouncing.
    if (p.run_contact && !p.stop_contact) begin
      st_d.sw_latch = 1'b1;
    end else if (p.stop_contact && !p.run_contact) begin
      st_d.sw_latch = 1'b0;
    end

    // Power clear drops latched faults; otherwise a fault would bar every
    // later start, since only a successful run set clears them.
    if (pclr) begin
      st_d.fault_start = 1'b0;
      st_d.fault_load  = 1'b0;
    end

    // Emergency tests sample status only at the gated clock.
    if (gev && s.run && !s.seq_ctl) begin
      if (phase == PH_PURGE && !p.speed_ok) begin
        st_d.fault_start = 1'b1;
      end
      if (phase == PH_LOAD && !p.pos_ok) begin
        st_d.fault_load = 1'b1;
      end
    end
    anyem = p.ext_emerg | st_q.fault_start | st_q.fault_load;
    cou_n = ~(pclr | anyem);

    // Run may only be entered from a finished stop sequence.
    interlock = p.heads_ret & not_rot & ~s.brake & ~s.seq_ctl & ~s.end_of_run;
    run_set   = 1'b0;
    if (!p.cart_ok || !cou_n) begin
      n.run = 1'b0;
    end else if (rsp) begin
      n.run   = s.run ? 1'b0 : interlock;
      run_set = ~s.run & interlock;
    end
    if (run_set) begin
      st_d.fault_start = 1'b0;
      st_d.fault_load  = 1'b0;
    end

    // Start sequence: run, purge, load, then sequence control.
    if (gev && s.run && !s.seq_ctl) begin
      unique case (phase)
        PH_IDLE:   n.purge = 1'b1;
        PH_PURGE:  n.load  = p.speed_ok;
        PH_LOAD: begin
          if (p.pos_ok) begin
            n.purge        = 1'b0;
            n.seq_ctl      = 1'b1;
            n.emerg_unload = 1'b0;
          end
        end
        PH_LOADED: n.seq_ctl = 1'b1;
      endcase
    end

    // Stop sequence: the fall of run sets end-of-run, which presets sequence
    // control; its timed clear starts the brake.
    if (s.run && !n.run) begin
      n.end_of_run = 1'b1;
    end
    if (s.end_of_run) begin
      n.seq_ctl = 1'b1;
    end
    if (gev && s.seq_ctl && !s.run) begin
      n.seq_ctl    = 1'b0;
      n.end_of_run = 1'b0;
      n.brake      = 1'b1;
      n.purge      = 1'b0;
      n.load       = 1'b0;
    end
    if (s.brake && not_rot) begin
      n.brake = 1'b0;
    end

    // Any emergency forces the heads off through the unload flop.
    if (anyem) begin
      n.emerg_unload = 1'b1;
    end

    // Power clear wins over everything it initialises.
    if (pclr) begin
      st_d.rot_cnt   = ROT_RST;
      n.emerg_unload = 1'b1;
      n.end_of_run   = 1'b0;
      n.timing_pulse = 1'b0;
    end

    // Delay counter counts last-tap periods and restarts whenever the state
    // changes, so each wait is measured from its own entry point. It stops
    // once the decode is met, so the wait stays elapsed until a tap nine edge.
    if ({n.run, n.purge, n.load, n.seq_ctl, n.brake} != {s.run, s.purge, s.load, s.seq_ctl, s.brake}) begin
      st_d.dly_cnt = DLY_RST;
    end else if (last_tick && !decode && st_q.dly_cnt != DLY_MAX) begin
      st_d.dly_cnt = st_q.dly_cnt + 8'h01;
    end

    st_d.seq       = n;
    st_d.o_tap9    = tap9;
    st_d.o_last    = last_tap;
    st_d.o_rsp     = rsp;
    st_d.o_sdm     = run_set;
    st_d.o_cou_n   = cou_n;
    st_d.o_dnr_n   = ~not_rot;
    st_d.o_nbc_n   = ~n.brake;
    st_d.o_anyem   = anyem;
    st_d.o_pm_init = (phase == PH_LOAD);
    st_d.o_hload   = n.load & ~n.emerg_unload;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // The run clear is immediate in the next-state logic rather than a true
  // asynchronous clear; it costs one cycle but keeps a single clock.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '{sync1: PINS_RST, sync2: PINS_RST, pre_cnt: PRE_CNT_RST, chain: CHAIN_RST,
                dly_cnt: DLY_RST, rot_cnt: ROT_RST, seq: SEQ_RST, o_cou_n: 1'b0,
                o_dnr_n: 1'b1, o_nbc_n: 1'b1, default: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flops
  // ==========================================================================
  assign countdown_tap_nine      = st_q.o_tap9;
  assign countdown_last_tap      = st_q.o_last;
  assign run_switch_pulse        = st_q.o_rsp;
  assign start_drive_motor_pulse = st_q.o_sdm;
  assign clear_or_unload_n       = st_q.o_cou_n;
  assign disk_not_rotating_n     = st_q.o_dnr_n;
  assign no_brake_cycle_n        = st_q.o_nbc_n;
  assign any_emergency           = st_q.o_anyem;
  assign position_monitor_init   = st_q.o_pm_init;
  assign heads_load_cmd          = st_q.o_hload;
  assign seq_state               = st_q.seq;

endmodule // sst_sequencer

// *** dv/sst_host_model.sv ***
`timescale 1ns/1ps

// Controller side of the start/stop line: flips the level on request and
// refuses a new flip until the old level has stood long enough.
module sst_host_model
  import sst_pkg::*;
#(
  parameter int unsigned HOLD = 4
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic toggle_req,
  output logic      line,
  output logic      busy
);
  logic [3:0] hold_q;

  // A level that stood shorter could be lost in the detector's shift stages.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      line   <= 1'b1;
      hold_q <= 4'h0;
    end else if (toggle_req && hold_q == 4'h0) begin
      line   <= ~line;
      hold_q <= HOLD[3:0];
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end
  end

  assign busy = (hold_q != 4'h0);
endmodule // sst_host_model

// *** dv/sst_props.sv ***
`timescale 1ns/1ps

module sst_props
  import sst_pkg::*;
(
  input wire logic     clk,
  input wire logic     sys_rst,
  input wire logic     power_clear_in,
  input wire logic     cartridge_seated_ok,
  input wire logic     run_switch_pulse,
  input wire logic     start_drive_motor_pulse,
  input wire logic     clear_or_unload_n,
  input wire logic     disk_not_rotating_n,
  input wire logic     no_brake_cycle_n,
  input wire logic     any_emergency,
  input wire sst_seq_s seq_state
);
  // ==========================================================================
  // Helper counter
  // ==========================================================================
  // A counter stands in for a 2560-long repetition, which tools cannot unroll.
  logic [15:0] tp_cnt_q;
  logic [15:0] tp_cnt_d;
  always_comb tp_cnt_d = seq_state.timing_pulse ? tp_cnt_q + 16'h0001 : 16'h0000;
  always_ff @(posedge clk) tp_cnt_q <= sys_rst ? 16'h0000 : tp_cnt_d;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_switch_pulse_single: assert property (run_switch_pulse |=> !run_switch_pulse)
    else $error("run switch pulse longer than one cycle");
  a_motor_on_set: assert property (start_drive_motor_pulse |-> seq_state.run && !$past(seq_state.run)
    && run_switch_pulse ##1 !start_drive_motor_pulse)
    else $error("motor pulse without run being set");
  a_run_set_cause: assert property ($rose(seq_state.run) |-> run_switch_pulse)
    else $error("run set without switch pulse");
  a_run_toggle_off: assert property (run_switch_pulse && $past(seq_state.run) |-> !seq_state.run)
    else $error("switch pulse did not clear run");
  a_run_interlock: assert property ($rose(seq_state.run) |-> $past(!seq_state.seq_ctl && !seq_state.end_of_run
    && no_brake_cycle_n && !disk_not_rotating_n))
    else $error("run set without interlocks");
  a_tp_one_period: assert property ($fell(seq_state.timing_pulse) |-> (tp_cnt_q == 16'h0A00)
    or ##[0:2] !clear_or_unload_n)
    else $error("timing pulse width wrong");
  a_phase_gated: assert property ($changed(seq_state.purge) || $changed(seq_state.load)
    |-> seq_state.timing_pulse || $past(seq_state.timing_pulse))
    else $error("purge or load changed outside gated clock");
  a_power_unload: assert property (power_clear_in |-> ##[1:4] (!clear_or_unload_n && seq_state.emerg_unload))
    else $error("power clear not seen");
  a_cart_clears_run: assert property (!cartridge_seated_ok |-> ##[1:4] !seq_state.run)
    else $error("run kept without cartridge");
  a_emerg_clears_run: assert property (any_emergency |-> ##[0:3] (!seq_state.run && !clear_or_unload_n))
    else $error("emergency did not clear run");
endmodule // sst_props

bind sst_sequencer sst_props u_props (
  .clk                     (clk),
  .sys_rst                 (sys_rst),
  .power_clear_in          (power_clear_in),
  .cartridge_seated_ok     (cartridge_seated_ok),
  .run_switch_pulse        (run_switch_pulse),
  .start_drive_motor_pulse (start_drive_motor_pulse),
  .clear_or_unload_n       (clear_or_unload_n),
  .disk_not_rotating_n     (disk_not_rotating_n),
  .no_brake_cycle_n        (no_brake_cycle_n),
  .any_emergency           (any_emergency),
  .seq_state               (seq_state)
);

// *** dv/sst_sequencer_test.sv ***
`timescale 1ns/1ps

module sst_sequencer_test
  import sst_pkg::*;
;
  localparam int RUN = 15, EOR = 14, PUR = 13, LOD = 12, SCT = 11, BRK = 10;
  localparam int RSP = 7, DNR = 5, NBC = 4, TAP = 3, COU = 2, AEM = 1;
  logic       clk, rst, pc, cart, hret, idx, ext, spd, posok, tog, spin, line;
  logic [1:0] sw;
  logic       tap9, ltap, rsp, sdm, cou_n, dnr_n, nbc_n, aem, pmi, hlc;
  sst_seq_s   st;
  logic [15:0] obs;
  int         n_mismatch, check_count;

  // One observation vector lets a single wait task watch any output bit except ltap and hlc.
  assign obs = {st, rsp, sdm, dnr_n, nbc_n, tap9, cou_n, aem, pmi};

  // Clock and a fake index sensor that pulses every other cycle while spinning.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) idx <= spin && !idx;

  sst_sequencer #(.LAST_TAP(3)) dut (
    .clk(clk), .sys_rst(rst), .power_clear_in(pc), .panel_run_stop_switch(sw),
    .host_start_stop_line(line), .cartridge_seated_ok(cart), .heads_retracted(hret),
    .disk_index_pulse(idx), .external_emergency(ext), .spindle_speed_ok(spd), .position_ok(posok),
    .countdown_tap_nine(tap9), .countdown_last_tap(ltap), .run_switch_pulse(rsp),
    .start_drive_motor_pulse(sdm), .clear_or_unload_n(cou_n), .disk_not_rotating_n(dnr_n),
    .no_brake_cycle_n(nbc_n), .any_emergency(aem), .position_monitor_init(pmi),
    .heads_load_cmd(hlc), .seq_state(st));

  sst_host_model u_host (.clk(clk), .sys_rst(rst), .toggle_req(tog), .line(line), .busy());

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task report_and_stop;
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  // Bounded wait; running out of cycles ends the run as a failure.
  task wt(input int i, input logic v, input int n);
    int k;
    for (k = 0; k < n; k++) begin
      @(posedge clk);
      #1;
      if (obs[i] === v) break;
    end
    if (k == n) begin
      chk(1'b0, "timeout");
      report_and_stop;
    end
  endtask

  task host_toggle;
    @(posedge clk) tog <= 1'b1;
    @(posedge clk) tog <= 1'b0;
  endtask

  task idle_wait;
    wt(NBC, 1'b1, 20000);
    wt(DNR, 1'b0, 5000);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task t_power;
    chk(st === SEQ_RST && nbc_n === 1'b1, "reset state");
    @(posedge clk) pc <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk(cou_n === 1'b0 && st.emerg_unload === 1'b1 && st.run === 1'b0, "power clear");
    @(posedge clk) pc <= 1'b0;
    wt(COU, 1'b1, 10);
    chk(dnr_n === 1'b1, "rotation delay after power clear");
  endtask

  task t_tap;
    int k;
    wt(TAP, 1'b1, 3000);
    k = 0;
    while (tap9 === 1'b1 && k < 3000) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(k == 1280, "tap nine half period");
    // Tap three of the short simulation chain: 800 ns period, 20 cycles high.
    k = 0;
    while (ltap !== 1'b0 && k < 100) begin
      @(posedge clk);
      #1;
      k++;
    end
    k = 0;
    while (ltap !== 1'b1 && k < 100) begin
      @(posedge clk);
      #1;
      k++;
    end
    k = 0;
    while (ltap === 1'b1 && k < 100) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(k == 20, "last tap half period");
  endtask

  task t_start_seq;
    wt(DNR, 1'b0, 5000);
    host_toggle;
    wt(RUN, 1'b1, 12);
    chk(sdm === 1'b1 && rsp === 1'b1, "motor pulse at run set");
    @(posedge clk);
    #1;
    chk(sdm === 1'b0 && rsp === 1'b0, "pulses last one cycle");
    wt(PUR, 1'b1, 20000);
    chk(st.load === 1'b0 && st.seq_ctl === 1'b0, "purge first");
    wt(LOD, 1'b1, 20000);
    repeat (2) @(posedge clk);
    #1;
    chk(pmi === 1'b1, "monitor init in load phase");
    wt(SCT, 1'b1, 20000);
    @(posedge clk);
    #1;
    chk(st.purge === 1'b0 && st.emerg_unload === 1'b0 && hlc === 1'b1, "start complete");
  endtask

  task t_stop;
    host_toggle;
    wt(RUN, 1'b0, 12);
    chk(sdm === 1'b0 && rsp === 1'b1, "pulse clears run");
    wt(EOR, 1'b1, 3);
    host_toggle;
    wt(RSP, 1'b1, 12);
    @(posedge clk);
    #1;
    chk(st.run === 1'b0, "run refused in stop sequence");
    wt(BRK, 1'b1, 20000);
    chk(st.seq_ctl === 1'b0 && st.end_of_run === 1'b0, "brake as seq ctl clears");
    idle_wait;
  endtask

  task t_spin;
    @(posedge clk) spin <= 1'b1;
    repeat (40) @(posedge clk);
    #1;
    chk(dnr_n === 1'b1, "rotation seen");
    host_toggle;
    wt(RSP, 1'b1, 12);
    @(posedge clk);
    #1;
    chk(st.run === 1'b0, "run refused while turning");
    @(posedge clk) spin <= 1'b0;
    wt(DNR, 1'b0, 5000);
    @(posedge clk) hret <= 1'b0;
    host_toggle;
    wt(RSP, 1'b1, 12);
    @(posedge clk);
    #1;
    chk(st.run === 1'b0, "run refused with heads loaded");
    @(posedge clk) hret <= 1'b1;
  endtask

  task t_cart;
    int n;
    @(posedge clk) sw <= 2'h1;
    @(posedge clk) sw <= 2'h0;
    @(posedge clk) sw <= 2'h1;
    @(posedge clk) sw <= 2'h0;
    n = 0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (rsp === 1'b1) n++;
    end
    chk(n == 1 && st.run === 1'b1, "one pulse from bouncing switch");
    @(posedge clk) cart <= 1'b0;
    wt(RUN, 1'b0, 5);
    @(posedge clk) cart <= 1'b1;
    wt(BRK, 1'b1, 20000);
    idle_wait;
  endtask

  task t_emerg;
    host_toggle;
    wt(RUN, 1'b1, 12);
    @(posedge clk) ext <= 1'b1;
    wt(RUN, 1'b0, 6);
    repeat (2) @(posedge clk);
    #1;
    chk(aem === 1'b1 && cou_n === 1'b0 && st.emerg_unload === 1'b1, "emergency abort");
    @(posedge clk) ext <= 1'b0;
    wt(BRK, 1'b1, 20000);
    idle_wait;
  endtask

  // A slow spindle at the purge test latches a start fault and aborts.
  task t_fault;
    @(posedge clk) spd <= 1'b0;
    host_toggle;
    wt(RUN, 1'b1, 12);
    wt(PUR, 1'b1, 20000);
    wt(AEM, 1'b1, 20000);
    chk(st.run === 1'b0 && st.load === 1'b0 && cou_n === 1'b0 && st.emerg_unload === 1'b1, "speed fault");
  endtask

  // Main sequence: reset for 8 cycles, then every scenario in turn.
  initial begin
    {rst, pc, sw, cart, hret, ext, spd, posok, tog, spin} = 11'h46C;
    n_mismatch = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    t_power;
    t_tap;
    t_start_seq;
    t_stop;
    t_spin;
    t_cart;
    t_emerg;
    t_fault;
    report_and_stop;
  end
endmodule // sst_sequencer_test
